// *** hw/cmc_ctrl_regs.sv ***
// Clock manager control registers with APB slave and configuration load port
//
// The implementer's own choice: register access over APB.
`timescale 1ns/10ps
module cmc_ctrl_regs (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Configuration bit stream load, same clock
  input wire logic cfg_wr_en,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  // Pins from outside the clock domain
  input wire logic config_done,
  input wire logic global_set_reset_n,
  input wire logic loop_lock_raw,
  // Manager controls
  output logic [5:0] duty_units_q,
  output logic loop_pll_q,
  output logic fb_delay_line_q,
  output logic double_rate_q,
  output logic [1:0] fast_edge_src_q,
  output logic [1:0] sys_clk_src_q,
  output logic analog_power_on_q,
  output logic manager_reset_q,
  output logic dll_reset_q,
  output logic data_bus_oe_n_q,
  output logic lock_q,
  output logic edge_clock_divider_tick_q
);
  logic [2:0] sync1_q, sync2_q;
  logic done_s, gsr_n_s, lock_s;
  logic [7:0] div_q, div_d, duty_q, duty_d, mode_q, mode_d;
  logic [7:0] src_q, src_d, ctrl_q, ctrl_d;
  logic [31:0] prdata_d;
  logic pready_d, pslverr_d;
  logic apb_wr, wr_en, gsr_hit, run_ok, div_clear;
  logic [7:0] wr_addr, wr_data, rd_byte;
  logic rd_hit;
  logic [5:0] duty_units_d;
  logic [1:0] fast_src_d, sys_src_d;
  logic pwr_d, mrst_d, drst_d, oe_n_d, lock_d;

  // Two-flop synchronisers for pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 3'h2;
      sync2_q <= 3'h2;
    end else begin
      sync1_q <= {loop_lock_raw, global_set_reset_n, config_done};
      sync2_q <= sync1_q;
    end
  end
  assign done_s = sync2_q[0];
  assign gsr_n_s = sync2_q[1];
  assign lock_s = sync2_q[2];

  assign gsr_hit = !gsr_n_s && !ctrl_q[cmc_pkg::CTRL_GSRIMM_BIT];

  // Write source: APB access phase first, then configuration stream
  always_comb begin
    apb_wr = psel && penable && pready && pwrite;
    wr_en = apb_wr || cfg_wr_en;
    wr_addr = apb_wr ? paddr : {cfg_addr[5:0], 2'b00};
    wr_data = apb_wr ? pwdata[7:0] : cfg_wdata;
  end

  // Register state
  always_comb begin
    div_d = div_q;
    duty_d = duty_q;
    mode_d = mode_q;
    src_d = src_q;
    ctrl_d = ctrl_q;
    if (wr_en) begin
      unique case (wr_addr)
        cmc_pkg::DIV_ADDR: div_d = wr_data & cmc_pkg::DIV_MASK;
        cmc_pkg::DUTY_ADDR: duty_d = wr_data & cmc_pkg::DUTY_MASK;
        cmc_pkg::MODE_ADDR: mode_d = wr_data & cmc_pkg::MODE_MASK;
        cmc_pkg::SRC_ADDR: src_d = wr_data & cmc_pkg::SRC_MASK;
        cmc_pkg::CTRL_ADDR: ctrl_d = wr_data & cmc_pkg::CTRL_MASK;
        default: ;
      endcase
    end
    // Divider's own reset bit returns its value to default
    if (div_d[cmc_pkg::DIV_RST_BIT]) begin
      div_d[3:0] = cmc_pkg::DIV_RST[3:0];
    end
    if (gsr_hit) begin
      div_d = cmc_pkg::DIV_RST;
      duty_d = cmc_pkg::DUTY_RST;
      mode_d = cmc_pkg::MODE_RST;
      src_d = cmc_pkg::SRC_RST;
      ctrl_d = cmc_pkg::CTRL_RST;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= cmc_pkg::DIV_RST;
      duty_q <= cmc_pkg::DUTY_RST;
      mode_q <= cmc_pkg::MODE_RST;
      src_q <= cmc_pkg::SRC_RST;
      ctrl_q <= cmc_pkg::CTRL_RST;
    end else begin
      div_q <= div_d;
      duty_q <= duty_d;
      mode_q <= mode_d;
      src_q <= src_d;
      ctrl_q <= ctrl_d;
    end
  end

  // APB answer: ready during the first access cycle
  always_comb begin
    rd_hit = 1'b1;
    unique case (paddr)
      cmc_pkg::DIV_ADDR: rd_byte = div_q;
      cmc_pkg::DUTY_ADDR: rd_byte = duty_q;
      cmc_pkg::MODE_ADDR: rd_byte = mode_q;
      cmc_pkg::SRC_ADDR: rd_byte = src_q;
      cmc_pkg::CTRL_ADDR: rd_byte = ctrl_q;
      cmc_pkg::STAT_ADDR: rd_byte = {3'h0, dll_reset_q, manager_reset_q, done_s,
                                     analog_power_on_q, lock_q};
      default: begin
        rd_byte = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
    pready_d = psel && !penable;
    pslverr_d = psel && !penable && !rd_hit;
    prdata_d = prdata;
    if (psel && !penable) begin
      prdata_d = (pwrite || !rd_hit) ? 32'h0000_0000 : {24'h00_0000, rd_byte};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= pready_d;
      pslverr <= pslverr_d;
      prdata <= prdata_d;
    end
  end

  // Manager outputs
  always_comb begin
    if (duty_q[7]) begin
      duty_units_d = 6'({duty_q[7:6], 3'h0}) + 6'(duty_q[5:3]) + 6'h01;
    end else begin
      duty_units_d = 6'({duty_q[7:6], 3'h0}) + 6'(duty_q[2:0]) + 6'h01;
    end
    run_ok = ctrl_q[cmc_pkg::CTRL_CFGRUN_BIT] || done_s;
    pwr_d = ctrl_q[cmc_pkg::CTRL_PWR_BIT] && run_ok;
    mrst_d = ctrl_q[cmc_pkg::CTRL_RST_BIT] || gsr_hit;
    drst_d = ctrl_q[cmc_pkg::CTRL_DLLRST_BIT] || mrst_d;
    oe_n_d = !run_ok;
    lock_d = lock_s && pwr_d && !mrst_d && !(drst_d && !mode_q[cmc_pkg::MODE_PLL_BIT]);
    fast_src_d = src_q[cmc_pkg::SRC_FAST_LSB +: 2];
    sys_src_d = src_q[cmc_pkg::SRC_SYS_LSB +: 2];
    if (sys_src_d == cmc_pkg::SRC_RESERVED) begin
      sys_src_d = cmc_pkg::SRC_BYPASS;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_units_q <= 6'h01;
      loop_pll_q <= 1'b0;
      fb_delay_line_q <= 1'b0;
      double_rate_q <= 1'b0;
      fast_edge_src_q <= 2'h0;
      sys_clk_src_q <= 2'h0;
      analog_power_on_q <= 1'b0;
      manager_reset_q <= 1'b0;
      dll_reset_q <= 1'b0;
      data_bus_oe_n_q <= 1'b1;
      lock_q <= 1'b0;
    end else begin
      duty_units_q <= duty_units_d;
      loop_pll_q <= mode_q[cmc_pkg::MODE_PLL_BIT];
      fb_delay_line_q <= mode_q[cmc_pkg::MODE_PLL_BIT] && mode_q[cmc_pkg::MODE_FB_BIT];
      double_rate_q <= !mode_q[cmc_pkg::MODE_PLL_BIT] && mode_q[cmc_pkg::MODE_DBL_BIT];
      fast_edge_src_q <= fast_src_d;
      sys_clk_src_q <= sys_src_d;
      analog_power_on_q <= pwr_d;
      manager_reset_q <= mrst_d;
      dll_reset_q <= drst_d;
      data_bus_oe_n_q <= oe_n_d;
      lock_q <= lock_d;
    end
  end

  assign div_clear = div_q[cmc_pkg::DIV_RST_BIT] || ctrl_q[cmc_pkg::CTRL_RST_BIT];

  cmc_edge_div #(
    .VAL_W(4)
  ) u_div (
    .clk(pclk),
    .rst_n(presetn),
    .clear(div_clear),
    .div_val(div_q[3:0]),
    .tick_q(edge_clock_divider_tick_q)
  );

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  duty_low_a: assert property (!duty_q[7] |=> duty_units_q ==
    6'({$past(duty_q[7:6]), 3'h0}) + 6'($past(duty_q[2:0])) + 6'h01)
    else $error("duty low range wrong");
  duty_high_a: assert property (duty_q[7] |=> duty_units_q ==
    6'({$past(duty_q[7:6]), 3'h0}) + 6'($past(duty_q[5:3])) + 6'h01)
    else $error("duty high range wrong");
  duty_range_a: assert property (##1 (duty_units_q - 6'h01) >> 3 ==
    6'($past(duty_q[7:6])))
    else $error("duty outside master range");
  duty_ignore_a: assert property ($stable(duty_q[7:6]) && $stable(duty_q[2:0]) &&
    !duty_q[7] |=> $stable(duty_units_q))
    else $error("unused field changed duty");
  pll_sel_a: assert property (##1 loop_pll_q == $past(mode_q[0]))
    else $error("loop type wrong");
  fb_sel_a: assert property (!mode_q[0] |=> !fb_delay_line_q)
    else $error("feedback select in delay mode");
  dbl_sel_a: assert property (mode_q[0] |=> !double_rate_q)
    else $error("double rate in phase mode");
  fast_src_a: assert property (##1 fast_edge_src_q == $past(src_q[5:4]))
    else $error("fast edge source wrong");
  sys_src_a: assert property (sys_clk_src_q != cmc_pkg::SRC_RESERVED)
    else $error("reserved system source");
  power_a: assert property (!ctrl_q[0] |=> !analog_power_on_q)
    else $error("power on while switched off");
  mgr_rst_a: assert property (ctrl_q[1] |=> manager_reset_q && !lock_q)
    else $error("manager not held in reset");
  dll_rst_a: assert property (ctrl_q[2] && !wr_en && !gsr_hit |=> dll_reset_q &&
    $stable(div_q) && $stable(duty_q))
    else $error("delay loop reset wrong");
  cfg_off_a: assert property (!ctrl_q[6] && !done_s |=>
    !analog_power_on_q && data_bus_oe_n_q && !lock_q)
    else $error("manager active before done");
  cfg_run_a: assert property (ctrl_q[6] && ctrl_q[0] && !gsr_hit |=> analog_power_on_q)
    else $error("manager not run in configuration");
  gsr_imm_a: assert property (ctrl_q[7] && !wr_en |=> $stable(ctrl_q) && $stable(mode_q))
    else $error("global reset not blocked");
  div_rst_a: assert property (div_q[7] |-> div_q[3:0] == 4'h0)
    else $error("divider value kept in reset");
  rsvd_a: assert property ((mode_q & ~cmc_pkg::MODE_MASK) == 8'h00 &&
    (ctrl_q & ~cmc_pkg::CTRL_MASK) == 8'h00)
    else $error("reserved bit set");
  div_bypass_a: assert property (div_q[3:0] == 4'h0 && !div_clear |=>
    edge_clock_divider_tick_q)
    else $error("bypass not every cycle");

  pll_mode_c: cover property (loop_pll_q && lock_q);
  dbl_rate_c: cover property (double_rate_q && duty_units_q == 6'h18);
  gsr_block_c: cover property (!gsr_n_s && ctrl_q[7]);
  cfg_run_c: cover property (!done_s && analog_power_on_q);
endmodule

// *** hw/cmc_edge_div.sv ***
// Divider producing a tick for the divided delay line source
`timescale 1ns/10ps
module cmc_edge_div #(
  parameter int VAL_W = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic clear,
  input wire logic [VAL_W-1:0] div_val,
  // Output
  output logic tick_q
);
  logic [3:0] cnt_q, cnt_d;
  logic tick_d;
  logic [3:0] ratio;

  always_comb begin
    // Zero in the low three bits means eight, except a whole value of zero, which ticks every cycle; larger values wrap modulo eight
    ratio = (div_val[2:0] == 3'h0) ? 4'h8 : {1'b0, div_val[2:0]};
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (clear) begin
      cnt_d = 4'h0;
    end else if (div_val == '0) begin
      cnt_d = 4'h0;
      tick_d = 1'b1;
    end else if (4'(cnt_q + 4'h1) >= ratio) begin
      cnt_d = 4'h0;
      tick_d = 1'b1;
    end else begin
      cnt_d = 4'(cnt_q + 4'h1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end
endmodule

// *** shared/cmc_pkg.sv ***
// Register map, field layout and reset values of the clock manager control block
package cmc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] DIV_IDX = 8'h02;
  localparam logic [7:0] DUTY_IDX = 8'h04;
  localparam logic [7:0] MODE_IDX = 8'h05;
  localparam logic [7:0] SRC_IDX = 8'h06;
  localparam logic [7:0] CTRL_IDX = 8'h07;
  localparam logic [7:0] STAT_IDX = 8'h08;
  localparam logic [7:0] DIV_ADDR = 8'(DIV_IDX * 4);
  localparam logic [7:0] DUTY_ADDR = 8'(DUTY_IDX * 4);
  localparam logic [7:0] MODE_ADDR = 8'(MODE_IDX * 4);
  localparam logic [7:0] SRC_ADDR = 8'(SRC_IDX * 4);
  localparam logic [7:0] CTRL_ADDR = 8'(CTRL_IDX * 4);
  localparam logic [7:0] STAT_ADDR = 8'(STAT_IDX * 4);
  // Writable bit masks; other bits are reserved
  localparam logic [7:0] DIV_MASK = 8'h8f;
  localparam logic [7:0] DUTY_MASK = 8'hff;
  localparam logic [7:0] MODE_MASK = 8'h15;
  localparam logic [7:0] SRC_MASK = 8'hf0;
  localparam logic [7:0] CTRL_MASK = 8'hc7;
  // Reset values
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [7:0] DUTY_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] SRC_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // Field positions
  localparam int DIV_RST_BIT = 7;
  localparam int MODE_PLL_BIT = 0;
  localparam int MODE_FB_BIT = 2;
  localparam int MODE_DBL_BIT = 4;
  localparam int SRC_FAST_LSB = 4;
  localparam int SRC_SYS_LSB = 6;
  localparam int CTRL_PWR_BIT = 0;
  localparam int CTRL_RST_BIT = 1;
  localparam int CTRL_DLLRST_BIT = 2;
  localparam int CTRL_CFGRUN_BIT = 6;
  localparam int CTRL_GSRIMM_BIT = 7;
  localparam int DUTY_MASTER_LSB = 6;
  localparam int DUTY_HI_LSB = 3;
  localparam int DUTY_LO_LSB = 0;
  // Output source codes
  localparam logic [1:0] SRC_BYPASS = 2'h0;
  localparam logic [1:0] SRC_RESERVED = 2'h3;
endpackage

// *** verif/cmc_cfg_model.sv ***
// Far-side model: configuration sequencer and chip pins
`timescale 1ns/10ps
module cmc_cfg_model (
  // Clock
  input wire logic pclk,
  // Configuration load
  output logic cfg_wr_en,
  output logic [7:0] cfg_addr,
  output logic [7:0] cfg_wdata,
  // Chip pins
  output logic config_done,
  output logic global_set_reset_n,
  output logic loop_lock_raw
);
  initial begin
    cfg_wr_en = 1'b0;
    cfg_addr = 8'h00;
    cfg_wdata = 8'h00;
    config_done = 1'b0;
    global_set_reset_n = 1'b1;
    loop_lock_raw = 1'b0;
  end
  // One byte from the bit stream; lines show the inverse once released
  task load(input logic [7:0] idx, input logic [7:0] d);
    @(posedge pclk);
    cfg_wr_en <= 1'b1;
    cfg_addr <= idx;
    cfg_wdata <= d;
    @(posedge pclk);
    cfg_wr_en <= 1'b0;
    cfg_addr <= ~idx;
    cfg_wdata <= ~d;
  endtask
  task pins(input logic done, input logic gsr_n, input logic lock);
    @(posedge pclk);
    config_done <= done;
    global_set_reset_n <= gsr_n;
    loop_lock_raw <= lock;
  endtask
endmodule

// *** verif/testbench.sv ***
// Self-checking bench for the clock manager control registers
`timescale 1ns/10ps
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, errv;
  logic [7:0] paddr, cfg_addr, cfg_wdata;
  logic [31:0] pwdata, prdata, rdv;
  logic cfg_wr_en, config_done, global_set_reset_n, loop_lock_raw;
  logic [5:0] duty_units_q;
  logic [1:0] fast_edge_src_q, sys_clk_src_q;
  logic loop_pll_q, fb_delay_line_q, double_rate_q, analog_power_on_q, manager_reset_q;
  logic dll_reset_q, data_bus_oe_n_q, lock_q, edge_clock_divider_tick_q;
  int failures, checked, cyc;

  cmc_ctrl_regs dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .cfg_wr_en, .cfg_addr, .cfg_wdata, .config_done, .global_set_reset_n,
    .loop_lock_raw, .duty_units_q, .loop_pll_q, .fb_delay_line_q, .double_rate_q,
    .fast_edge_src_q, .sys_clk_src_q, .analog_power_on_q, .manager_reset_q, .dll_reset_q,
    .data_bus_oe_n_q, .lock_q, .edge_clock_divider_tick_q);
  cmc_cfg_model far (.pclk, .cfg_wr_en, .cfg_addr, .cfg_wdata, .config_done,
    .global_set_reset_n, .loop_lock_raw);

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task end_sim;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      end_sim;
    end
  end

  task chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t read %h expected %h", $time, got, exp);
    end
  endtask

  task chk_out(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t port %h expected %h", $time, got, exp);
    end
  endtask

  // APB transfer; waits for pready, takes the answer at that edge
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Request held until the edge at which pready is sampled high
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task rdchk(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk_reg(rdv, {24'h00_0000, e});
  endtask

  task settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask

  task t_reset;
    chk_out({2'b00, duty_units_q}, 8'h01);
    chk_out({7'h00, data_bus_oe_n_q}, 8'h01);
    rdchk(cmc_pkg::MODE_ADDR, 8'h00);
    rdchk(cmc_pkg::SRC_ADDR, 8'h00);
    rdchk(cmc_pkg::CTRL_ADDR, 8'h00);
    rdchk(8'h3c, 8'h00);
    chk_out({7'h00, errv}, 8'h01);
  endtask

  task t_duty;
    logic [7:0] v [5] = '{8'h4c, 8'h74, 8'hf0, 8'h3f, 8'hb8};
    logic [7:0] e [5] = '{8'h0d, 8'h0d, 8'h1f, 8'h08, 8'h18};
    for (int i = 0; i < 5; i++) begin
      wr(cmc_pkg::DUTY_ADDR, v[i]);
      settle(2);
      chk_out({2'b00, duty_units_q}, e[i]);
    end
  endtask

  task t_mode;
    wr(cmc_pkg::MODE_ADDR, 8'hff);
    settle(2);
    rdchk(cmc_pkg::MODE_ADDR, 8'h15);
    chk_out({7'h00, loop_pll_q}, 8'h01);
    chk_out({7'h00, fb_delay_line_q}, 8'h01);
    chk_out({7'h00, double_rate_q}, 8'h00);
    wr(cmc_pkg::MODE_ADDR, 8'h14);
    settle(2);
    chk_out({7'h00, loop_pll_q}, 8'h00);
    chk_out({7'h00, fb_delay_line_q}, 8'h00);
    chk_out({7'h00, double_rate_q}, 8'h01);
  endtask

  task t_src;
    for (int c = 0; c < 4; c++) begin
      wr(cmc_pkg::SRC_ADDR, {2'(c), 2'(c), 4'hf});
      settle(2);
      chk_out({6'h00, fast_edge_src_q}, 8'(c));
      chk_out({6'h00, sys_clk_src_q}, (c == 3) ? 8'h00 : 8'(c));
      rdchk(cmc_pkg::SRC_ADDR, {2'(c), 2'(c), 4'h0});
    end
  endtask

  task t_ctrl;
    wr(cmc_pkg::DUTY_ADDR, 8'h4c);
    far.pins(1'b1, 1'b1, 1'b1);
    wr(cmc_pkg::CTRL_ADDR, 8'h01);
    settle(4);
    chk_out({7'h00, analog_power_on_q}, 8'h01);
    chk_out({7'h00, data_bus_oe_n_q}, 8'h00);
    chk_out({7'h00, lock_q}, 8'h01);
    rdchk(cmc_pkg::STAT_ADDR, 8'h07);
    wr(cmc_pkg::CTRL_ADDR, 8'h03);
    settle(2);
    chk_out({6'h00, manager_reset_q, lock_q}, 8'h02);
    wr(cmc_pkg::CTRL_ADDR, 8'h05);
    settle(2);
    chk_out({6'h00, manager_reset_q, dll_reset_q}, 8'h01);
    rdchk(cmc_pkg::DUTY_ADDR, 8'h4c);
    wr(cmc_pkg::CTRL_ADDR, 8'h00);
    settle(2);
    chk_out({7'h00, analog_power_on_q}, 8'h00);
    far.pins(1'b0, 1'b1, 1'b1);
    wr(cmc_pkg::CTRL_ADDR, 8'h01);
    settle(4);
    chk_out({5'h00, analog_power_on_q, data_bus_oe_n_q, lock_q}, 8'h02);
    wr(cmc_pkg::CTRL_ADDR, 8'h41);
    settle(2);
    chk_out({6'h00, analog_power_on_q, data_bus_oe_n_q}, 8'h02);
    far.load(cmc_pkg::DUTY_IDX, 8'hf0);
    settle(2);
    chk_out({2'b00, duty_units_q}, 8'h1f);
  endtask

  task t_gsr;
    far.pins(1'b1, 1'b1, 1'b0);
    wr(cmc_pkg::CTRL_ADDR, 8'h01);
    wr(cmc_pkg::DUTY_ADDR, 8'h55);
    far.pins(1'b1, 1'b0, 1'b0);
    settle(4);
    rdchk(cmc_pkg::DUTY_ADDR, 8'h00);
    far.pins(1'b1, 1'b1, 1'b0);
    settle(4);
    wr(cmc_pkg::CTRL_ADDR, 8'h81);
    wr(cmc_pkg::DUTY_ADDR, 8'h55);
    wr(cmc_pkg::DIV_ADDR, 8'h03);
    far.pins(1'b1, 1'b0, 1'b0);
    settle(4);
    rdchk(cmc_pkg::DUTY_ADDR, 8'h55);
    rdchk(cmc_pkg::CTRL_ADDR, 8'h81);
    rdchk(cmc_pkg::DIV_ADDR, 8'h03);
    far.pins(1'b1, 1'b1, 1'b0);
    settle(4);
    wr(cmc_pkg::CTRL_ADDR, 8'h00);
  endtask

  task t_div;
    logic [7:0] v [5] = '{8'h00, 8'h02, 8'h08, 8'h09, 8'h82};
    logic [7:0] e [5] = '{8'h10, 8'h08, 8'h02, 8'h10, 8'h00};
    int n;
    for (int i = 0; i < 5; i++) begin
      wr(cmc_pkg::DIV_ADDR, v[i]);
      settle(10);
      n = 0;
      repeat (16) begin
        @(negedge pclk);
        n += int'(edge_clock_divider_tick_q);
      end
      chk_out(8'(n), e[i]);
    end
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    failures = 0;
    checked = 0;
    cyc = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_duty;
    t_mode;
    t_src;
    t_ctrl;
    t_gsr;
    t_div;
    end_sim;
  end
endmodule
